// File: autoneg_regs_pkg.sv
// Shared constants and carriers for the negotiation status registers
`default_nettype none
package autoneg_regs_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_PARTNER = 8'h94;
  localparam logic [ADDR_W-1:0] OFS_EXPANSION = 8'h98;
  localparam logic [ADDR_W-1:0] OFS_NEXT_PAGE = 8'h9C;
  localparam logic [ADDR_W-1:0] OFS_SUMMARY = 8'hC0;

  // Reset values
  localparam logic [DATA_W-1:0] RST_PARTNER = 16'h0000;
  localparam logic [DATA_W-1:0] RST_EXPANSION = 16'h0004;
  localparam logic [DATA_W-1:0] RST_NEXT_PAGE = 16'h2001;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

  // Partner ability fields
  localparam int PA_MORE_PAGES = 15;
  localparam int PA_ACK = 14;
  localparam int PA_FAULT = 13;
  localparam logic [DATA_W-1:0] PA_KEEP_MASK = 16'hA3FF;

  // Next page transmit fields
  localparam int NP_MORE = 15;
  localparam int NP_MSG = 13;
  localparam int NP_COMPLY = 12;
  localparam int NP_TOGGLE = 11;
  localparam logic [DATA_W-1:0] NP_WR_MASK = 16'hB7FF;

  // Expansion fields
  localparam int EX_PDF = 4;
  localparam int EX_PNP = 3;
  localparam int EX_LNP = 2;
  localparam int EX_PAGE = 1;
  localparam int EX_PAN = 0;

  // Status summary fields
  localparam int SUM_PAGE = 8;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic valid;
    logic next_page;
    logic [DATA_W-1:0] word;
  } lcw_rx_t;

  typedef struct packed {
    logic parallel_fault;
    logic partner_an_capable;
    logic ack_valid;
    logic ack;
    logic np_sent;
    logic done;
  } neg_status_t;

endpackage
`default_nettype wire

// File: sticky_flag.sv
// Sticky event flag where a set in the clearing cycle wins
`timescale 1ns/1ps
`default_nettype none
module sticky_flag (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic set,
  input wire logic clr,
  output logic flag
);
  logic flag_q;
  logic flag_d;

  assign flag_d = set | (flag_q & ~clr);
  assign flag = flag_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end
endmodule // sticky_flag
`default_nettype wire

// File: field_reg.sv
// Loadable word register with a fixed reset value
`timescale 1ns/1ps
`default_nettype none
module field_reg #(
  parameter int W = 16,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] val_q;
  logic [W-1:0] val_d;

  initial begin
    if (W < 1) begin
      $error("field_reg width must be at least one");
    end
  end

  assign val_d = load ? din : val_q;
  assign dout = val_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      val_q <= RST_VAL;
    end else begin
      val_q <= val_d;
    end
  end
endmodule // field_reg
`default_nettype wire

// File: autoneg_partner_nextpage_regs.sv
// Negotiation partner ability, expansion and next page registers
//
// Overview of operation
// - Read-only partner ability word at 0094h, reset 0000h.
// - With next pages, partner word refreshes once negotiation completes.
// - Bit 15 shows the partner wants a next page.
// - Bit 14 tracks partner acknowledge from incoming pulse bursts.
// - Bit 13 shows partner remote fault.
// - Bits 12..10 read zero; software writes zero there.
// - Bits 9..5 show partner four-pair, fast and ten abilities.
// - Bits 4..0 hold partner selector exactly as received.
// - Expansion word resets to 0004h; bits 15..5 read zero.
// - Expansion bit 4 shows a parallel detection fault.
// - Expansion bit 3 shows partner next page capability.
// - Expansion bit 2 shows local next page capability, reset one.
// - Expansion bit 1 sets on page receipt, clears on expansion read.
// - Expansion bit 0 shows partner negotiation capability.
// - Read-write next page word at 009Ch, reset 2001h, is sent.
// - Bit 13 selects message page or unformatted page, default one.
// - Bit 11 is read-only, inverse of previous exchanged toggle.
// - Bits 10..0 hold the code field, default null message.
// - Summary bit 8 mirrors page flag; summary read never clears it.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module autoneg_partner_nextpage_regs #(
  parameter logic LOCAL_LOCAL_NEXT_PAGE_CAPABLE = 1'b1
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire autoneg_regs_pkg::bus_req_t BUS,
  output logic [autoneg_regs_pkg::DATA_W-1:0] RDATA,
  input wire autoneg_regs_pkg::lcw_rx_t LCW_RX,
  input wire autoneg_regs_pkg::neg_status_t NEG_STATUS,
  output logic [autoneg_regs_pkg::DATA_W-1:0] NEXT_PAGE_WORD,
  output logic PAGE_RECEIVED
);
  import autoneg_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  logic sel_partner;
  logic sel_expansion;
  logic sel_next_page;
  logic sel_summary;
  logic wr_next_page;
  logic rd_expansion;

  assign sel_partner = BUS.addr == OFS_PARTNER;
  assign sel_expansion = BUS.addr == OFS_EXPANSION;
  assign sel_next_page = BUS.addr == OFS_NEXT_PAGE;
  assign sel_summary = BUS.addr == OFS_SUMMARY;
  // Only the next page word takes writes
  assign wr_next_page = BUS.wr & sel_next_page;
  assign rd_expansion = BUS.rd & sel_expansion;

  ////////////////////////////////////////////////////////////////////////////
  // Received link code words

  logic base_load;
  logic np_rx;
  logic [DATA_W-1:0] rx_masked;
  logic [DATA_W-1:0] partner_word;
  logic [DATA_W-1:0] shadow_word;
  logic np_pending;
  logic np_commit;
  logic partner_load;
  logic [DATA_W-1:0] partner_din;

  assign base_load = LCW_RX.valid & ~LCW_RX.next_page;
  assign np_rx = LCW_RX.valid & LCW_RX.next_page;
  // Reserved bits never reach storage
  assign rx_masked = LCW_RX.word & PA_KEEP_MASK;
  // Latest next page waits until negotiation is done
  assign np_commit = NEG_STATUS.done & np_pending;
  assign partner_load = base_load | np_commit;
  assign partner_din = base_load ? rx_masked : shadow_word;

  field_reg #(
    .W(DATA_W),
    .RST_VAL(RST_PARTNER)
  ) u_partner (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .load(partner_load),
    .din(partner_din),
    .dout(partner_word)
  );

  field_reg #(
    .W(DATA_W),
    .RST_VAL(ZERO_WORD)
  ) u_shadow (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .load(np_rx),
    .din(rx_masked),
    .dout(shadow_word)
  );

  sticky_flag u_np_pending (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .set(np_rx),
    .clr(np_commit | base_load),
    .flag(np_pending)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge, partner next page capability and page flag

  logic ack_q;
  logic ack_d;
  logic partner_np_q;
  logic partner_np_d;
  logic page_flag;

  assign ack_d = NEG_STATUS.ack_valid ? NEG_STATUS.ack : ack_q;
  // Captured from the partner base page only
  assign partner_np_d = base_load ? LCW_RX.word[PA_MORE_PAGES] :
                        partner_np_q;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ack_q <= 1'b0;
      partner_np_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
      partner_np_q <= partner_np_d;
    end
  end

  // A page arriving in the clearing read keeps the flag set
  sticky_flag u_page_rx (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .set(LCW_RX.valid),
    .clr(rd_expansion),
    .flag(page_flag)
  );

  assign PAGE_RECEIVED = page_flag;

  ////////////////////////////////////////////////////////////////////////////
  // Next page transmit word

  logic [DATA_W-1:0] np_stored;
  logic [DATA_W-1:0] np_din;
  logic toggle_q;
  logic toggle_d;

  // Toggle and reserved bit are not writable
  assign np_din = BUS.wdata & NP_WR_MASK;

  field_reg #(
    .W(DATA_W),
    .RST_VAL(RST_NEXT_PAGE & NP_WR_MASK)
  ) u_next_page (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .load(wr_next_page),
    .din(np_din),
    .dout(np_stored)
  );

  // Each exchanged next page flips the toggle sent in the next one
  assign toggle_d = NEG_STATUS.np_sent ? ~toggle_q : toggle_q;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      toggle_q <= RST_NEXT_PAGE[NP_TOGGLE];
    end else begin
      toggle_q <= toggle_d;
    end
  end

  logic [DATA_W-1:0] np_view;

  assign np_view = np_stored | ({{(DATA_W-1){1'b0}}, toggle_q} << NP_TOGGLE);

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      NEXT_PAGE_WORD <= RST_NEXT_PAGE;
    end else begin
      NEXT_PAGE_WORD <= np_view;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read views

  logic [DATA_W-1:0] partner_view;
  logic [DATA_W-1:0] expansion_view;
  logic [DATA_W-1:0] summary_view;
  logic [DATA_W-1:0] rdata_d;

  // Bits 15, 13 and 9..0 come straight from the received word
  assign partner_view = (partner_word & ~(16'h0001 << PA_ACK)) |
                        ({{(DATA_W-1){1'b0}}, ack_q} << PA_ACK);

  assign expansion_view = {
    11'h000,
    NEG_STATUS.parallel_fault,
    partner_np_q,
    LOCAL_LOCAL_NEXT_PAGE_CAPABLE,
    page_flag,
    NEG_STATUS.partner_an_capable
  };

  assign summary_view = {{(DATA_W-1){1'b0}}, page_flag} << SUM_PAGE;

  assign rdata_d = !BUS.rd ? ZERO_WORD :
                   sel_partner ? partner_view :
                   sel_expansion ? expansion_view :
                   sel_next_page ? np_view :
                   sel_summary ? summary_view : ZERO_WORD;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= ZERO_WORD;
    end else begin
      RDATA <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  initial begin
    if (DATA_W != 16 || ADDR_W < 8) begin
      $error("register widths do not fit this block");
    end
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  sequence s_base_page;
    LCW_RX.valid && !LCW_RX.next_page;
  endsequence

  sequence s_exp_read;
    BUS.rd && sel_expansion;
  endsequence

  sequence s_summary_read;
    BUS.rd && sel_summary;
  endsequence

  a_base_capture: assert property (
    s_base_page |=> partner_word == ($past(LCW_RX.word) & PA_KEEP_MASK))
    else $error("base page not captured");

  a_partner_reserved: assert property (
    BUS.rd && sel_partner |=> RDATA[12:10] == 3'h0)
    else $error("partner reserved bits not zero");

  a_np_commit: assert property (
    NEG_STATUS.done && np_pending && !LCW_RX.valid
    |=> partner_word == $past(shadow_word) && !np_pending)
    else $error("next page not committed on completion");

  a_ack_track: assert property (
    NEG_STATUS.ack_valid ##1 BUS.rd && sel_partner
    |=> RDATA[PA_ACK] == $past(NEG_STATUS.ack, 2))
    else $error("acknowledge bit not tracking");

  a_page_set: assert property (
    LCW_RX.valid |=> page_flag && PAGE_RECEIVED)
    else $error("page flag not set");

  a_page_clear: assert property (
    s_exp_read and (page_flag && !LCW_RX.valid)
    |=> RDATA[EX_PAGE] && !page_flag)
    else $error("page flag not cleared by expansion read");

  a_summary_keep: assert property (
    s_summary_read and (page_flag && !rd_expansion)
    |=> RDATA[SUM_PAGE] && page_flag)
    else $error("summary read disturbed page flag");

  a_exp_upper: assert property (
    s_exp_read |=> RDATA[15:5] == 11'h000 && RDATA[EX_LNP] == LOCAL_LOCAL_NEXT_PAGE_CAPABLE)
    else $error("expansion fixed bits wrong");

  a_toggle_flip: assert property (
    NEG_STATUS.np_sent |=> toggle_q != $past(toggle_q) ##1
    NEXT_PAGE_WORD[NP_TOGGLE] == $past(toggle_q))
    else $error("toggle did not invert");

  a_partner_ro: assert property (
    BUS.wr && sel_partner && !LCW_RX.valid && !NEG_STATUS.done
    |=> $stable(partner_word))
    else $error("write altered partner word");

  a_np_write: assert property (
    BUS.wr && sel_next_page ##2 BUS.rd && sel_next_page
    |=> RDATA == (($past(BUS.wdata, 3) & NP_WR_MASK) |
                  ({15'h0000, toggle_q} << NP_TOGGLE)))
    else $error("next page write not stored");

endmodule // autoneg_partner_nextpage_regs
`default_nettype wire

// File: autoneg_peer_model.sv
// Far-side negotiation engine model driving received pages and status
`timescale 1ns/1ps
`default_nettype none
module autoneg_peer_model (
  input wire logic clk,
  output var autoneg_regs_pkg::lcw_rx_t lcw,
  output var autoneg_regs_pkg::neg_status_t neg
);
  import autoneg_regs_pkg::*;
  initial begin
    lcw = '0;
    neg = '0;
  end
  // One received page; the word is scrambled once valid drops
  task automatic page(input logic np, input logic [DATA_W-1:0] w);
    @(posedge clk);
    lcw <= '{1'b1, np, w};
    @(posedge clk);
    lcw <= '{1'b0, 1'b0, ~w};
  endtask
  // One-cycle status strobe: 0 loads ack, 1 next page sent, 2 done
  task automatic strobe(input int k, input logic a);
    @(posedge clk);
    neg.ack_valid <= (k == 0);
    neg.ack <= a;
    neg.np_sent <= (k == 1);
    neg.done <= (k == 2);
    @(posedge clk);
    neg.ack_valid <= 1'b0;
    neg.np_sent <= 1'b0;
    neg.done <= 1'b0;
  endtask
  task automatic levels(input logic pf, input logic an);
    @(posedge clk);
    neg.parallel_fault <= pf;
    neg.partner_an_capable <= an;
  endtask
endmodule // autoneg_peer_model
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the negotiation status register block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import autoneg_regs_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  bus_req_t bus = '0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] npw;
  logic page_rx;
  lcw_rx_t lcw;
  neg_status_t neg;
  int n_errors = 0;
  int cmp_count = 0;

  always #10 clk_sys = ~clk_sys;

  autoneg_partner_nextpage_regs i_dut (
    .CLK_SYS(clk_sys),
    .RST_N(rst_n),
    .BUS(bus),
    .RDATA(rdata),
    .LCW_RX(lcw),
    .NEG_STATUS(neg),
    .NEXT_PAGE_WORD(npw),
    .PAGE_RECEIVED(page_rx)
  );
  autoneg_peer_model i_peer (.clk(clk_sys), .lcw(lcw), .neg(neg));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [DATA_W-1:0] got,
                     input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    bus <= '0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk_sys);
    bus <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk_sys);
    bus <= '0;
    #1;
    chk(rdata, e);
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    #1;
    chk(npw, 16'h2001);
    chk({15'h0000, page_rx}, 16'h0000);
    rd(8'h94, 16'h0000);
    rd(8'h98, 16'h0004);
    rd(8'h9C, 16'h2001);
  endtask
  task automatic t_base(input logic [15:0] w, input logic [15:0] pa,
                       input logic [15:0] ex);
    i_peer.page(1'b0, w);
    #1;
    chk({15'h0000, page_rx}, 16'h0001);
    rd(8'hC0, 16'h0100);
    chk({15'h0000, page_rx}, 16'h0001);
    rd(8'h94, pa);
    rd(8'h98, ex);
    chk({15'h0000, page_rx}, 16'h0000);
    rd(8'h98, ex & 16'hFFFD);
  endtask
  task automatic t_status();
    i_peer.strobe(0, 1'b1);
    rd(8'h94, 16'h4015);
    i_peer.strobe(0, 1'b0);
    rd(8'h94, 16'h0015);
    i_peer.levels(1'b1, 1'b1);
    rd(8'h98, 16'h0015);
    i_peer.levels(1'b0, 1'b0);
    rd(8'h98, 16'h0004);
  endtask
  task automatic t_next_page();
    i_peer.page(1'b1, 16'h1234);
    rd(8'h94, 16'h0015);
    i_peer.strobe(2, 1'b0);
    rd(8'h94, 16'h0234);
  endtask
  task automatic t_np_write();
    wr(8'h9C, 16'hFFFF);
    @(posedge clk_sys);
    #1;
    chk(npw, 16'hB7FF);
    rd(8'h9C, 16'hB7FF);
    i_peer.strobe(1, 1'b0);
    rd(8'h9C, 16'hBFFF);
    i_peer.strobe(1, 1'b0);
    rd(8'h9C, 16'hB7FF);
    wr(8'h9C, 16'h0800);
    rd(8'h9C, 16'h0000);
    wr(8'h94, 16'hE3FF);
    wr(8'h98, 16'hFFFF);
    rd(8'h94, 16'h0234);
    rd(8'h98, 16'h0006);
    rd(8'h98, 16'h0004);
    rd(8'h00, 16'h0000);
  endtask
  task automatic t_mid_reset();
    i_peer.page(1'b0, 16'hFFFF);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    #1;
    chk({15'h0000, page_rx}, 16'h0000);
    chk(npw, 16'h2001);
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset_values();
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_errors++;
    $display("Run limit reached at t=%0t", $time);
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset_values();
    t_base(16'hFFFF, 16'hA3FF, 16'h000E);
    t_base(16'h5C15, 16'h0015, 16'h0006);
    t_status();
    t_next_page();
    t_np_write();
    t_mid_reset();
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
